// file: logic/psc_regs.svh
// Constants of the pressure sensor command port
`ifndef PSC_REGS_SVH
`define PSC_REGS_SVH
`define PSC_ADDR_HI        6'h3b
`define PSC_CMD_RESET      8'h1e
`define PSC_CMD_RESULT     8'h00
`define PSC_CMD_PRESS_BASE 8'h40
`define PSC_CMD_TEMP_BASE  8'h50
`define PSC_CMD_MEM_BASE   8'ha0
`define PSC_MEM_WORDS      8
`define PSC_MEM_WIDTH      16
`define PSC_RESULT_BITS    24
`define PSC_CONV_US_256    600
`define PSC_CLK_MHZ        40
`endif

// file: logic/psc_pkg.sv
// Types of the pressure sensor command port
package psc_pkg;
    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_ADDR  = 7'h02,
        ST_AACK  = 7'h04,
        ST_CMD   = 7'h08,
        ST_CACK  = 7'h10,
        ST_TX    = 7'h20,
        ST_MACK  = 7'h40
    } psc_state_e;
    typedef struct packed {
        logic sclIn;
        logic sdaIn;
    } psc_pins_s;
    typedef struct packed {
        logic        start;
        logic        isTemp;
        logic [2:0]  ratio;
    } psc_conv_s;
endpackage

// file: logic/psc_cal_mem.sv
// Calibration memory: eight words, registered read port, loaded at reset command
module psc_cal_mem #(
    parameter int WORDS = 8,
    parameter int WIDTH = 16
) (
    input  wire logic                     sys_clk,
    input  wire logic                     srst,
    input  wire logic                     clkEn,
    input  wire logic                     load,
    input  wire logic [WORDS*WIDTH-1:0]   loadData,
    input  wire logic [$clog2(WORDS)-1:0] rdAddr,
    output logic      [WIDTH-1:0]         rdData
);
    logic [WIDTH-1:0] mem_q [WORDS];

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            for (int i = 0; i < WORDS; i++) begin
                mem_q[i] <= '0;
            end
        end else if (clkEn && load) begin
            for (int i = 0; i < WORDS; i++) begin
                mem_q[i] <= loadData[i*WIDTH +: WIDTH];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdData <= '0;
        end else if (clkEn) begin
            rdData <= mem_q[rdAddr];
        end
    end
endmodule

// file: logic/psc_i2c_port.sv
// I2C slave command port of the pressure sensor
`include "psc_regs.svh"
module psc_i2c_port #(
    parameter int CONV_US_256 = `PSC_CONV_US_256,
    parameter int CLK_MHZ     = `PSC_CLK_MHZ
) (
    input  wire logic                  sys_clk,
    input  wire logic                  srst,
    input  wire logic                  clkEn,
    input  wire logic                  sclIn,
    input  wire logic                  sdaIn,
    output logic                       sdaOut,
    output logic                       sdaOe,
    input  wire logic                  address_select_pin,
    input  wire logic [127:0]          calContents,
    output logic                       convStart,
    output logic                       convTemp,
    output logic [2:0]                 oversampling_ratio,
    input  wire logic [23:0]           raw_pressure_value,
    input  wire logic [23:0]           raw_temperature_value,
    output logic                       busy
);
    localparam int CONV_CYC = CONV_US_256 * CLK_MHZ;

    psc_pkg::psc_pins_s  s1_q;
    psc_pkg::psc_pins_s  s2_q;
    psc_pkg::psc_pins_s  s3_q;
    psc_pkg::psc_state_e state_q;
    psc_pkg::psc_conv_s  conv;
    logic [7:0]          shift_q;
    logic [3:0]          bitCnt_q;
    logic                rnw_q;
    logic [23:0]         txData_q;
    logic                memMode_q;
    logic [2:0]          memAddr_q;
    logic                resultValid_q;
    logic                corrupt_q;
    logic [31:0]         convCnt_q;
    logic [1:0]          asel_q;
    logic [15:0]         memWord;
    logic                memLoad_q;
    logic                sclRise;
    logic                sclFall;
    logic                startCond;
    logic                stopCond;
    logic                cmdDone;
    logic                memActive;
    logic [7:0]          cmdByte;

    // Pins pass two flops; third stage used only for edges
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s1_q <= '1;
            s2_q <= '1;
            s3_q <= '1;
        end else if (clkEn) begin
            s1_q <= '{sclIn: sclIn, sdaIn: sdaIn};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign sclRise = s2_q.sclIn && !s3_q.sclIn;
    assign sclFall = !s2_q.sclIn && s3_q.sclIn;
    assign startCond = s2_q.sclIn && s3_q.sclIn && !s2_q.sdaIn && s3_q.sdaIn;
    assign stopCond  = s2_q.sclIn && s3_q.sclIn && s2_q.sdaIn && !s3_q.sdaIn;
    assign cmdByte   = {shift_q[6:0], s2_q.sdaIn};
    assign cmdDone   = (state_q == psc_pkg::ST_CMD) && sclRise && (bitCnt_q == 4'd7);
    assign memActive = memMode_q;

    // Strap pin is asynchronous too, so it gets the same two flops
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            asel_q <= 2'b00;
        end else if (clkEn) begin
            asel_q <= {asel_q[0], address_select_pin};
        end
    end

    psc_cal_mem #(
        .WORDS (`PSC_MEM_WORDS),
        .WIDTH (`PSC_MEM_WIDTH)
    ) u_mem (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .clkEn    (clkEn),
        .load     (memLoad_q),
        .loadData (calContents),
        .rdAddr   (memAddr_q),
        .rdData   (memWord)
    );

    // Bus state machine
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_q  <= psc_pkg::ST_IDLE;
            bitCnt_q <= '0;
            shift_q  <= '0;
            rnw_q    <= 1'b0;
        end else if (clkEn) begin
            if (startCond) begin
                state_q  <= psc_pkg::ST_ADDR;
                bitCnt_q <= '0;
            end else if (stopCond) begin
                state_q <= psc_pkg::ST_IDLE;
            end else if (sclRise) begin
                unique case (state_q)
                    psc_pkg::ST_IDLE: begin
                        state_q <= psc_pkg::ST_IDLE;
                    end
                    psc_pkg::ST_ADDR, psc_pkg::ST_CMD: begin
                        shift_q  <= cmdByte;
                        bitCnt_q <= bitCnt_q + 4'd1;
                        if (bitCnt_q == 4'd7) begin
                            bitCnt_q <= '0;
                            if (state_q == psc_pkg::ST_CMD) begin
                                state_q <= psc_pkg::ST_CACK;
                            end else if (shift_q[6:0] == {`PSC_ADDR_HI, !asel_q[1]}) begin
                                rnw_q   <= s2_q.sdaIn;
                                state_q <= psc_pkg::ST_AACK;
                            end else begin
                                state_q <= psc_pkg::ST_IDLE;
                            end
                        end
                    end
                    psc_pkg::ST_AACK: begin
                        state_q <= rnw_q ? psc_pkg::ST_TX : psc_pkg::ST_CMD;
                    end
                    psc_pkg::ST_CACK: begin
                        state_q <= psc_pkg::ST_CMD;
                    end
                    psc_pkg::ST_TX: begin
                        bitCnt_q <= bitCnt_q + 4'd1;
                        if (bitCnt_q == 4'd7) begin
                            bitCnt_q <= '0;
                            state_q  <= psc_pkg::ST_MACK;
                        end
                    end
                    // no ack frees a held bus
                    psc_pkg::ST_MACK: begin
                        state_q <= s2_q.sdaIn ? psc_pkg::ST_IDLE : psc_pkg::ST_TX;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            conv      <= '0;
            memMode_q <= 1'b0;
            memAddr_q <= '0;
            memLoad_q <= 1'b0;
        end else if (clkEn) begin
            conv.start <= 1'b0;
            memLoad_q  <= 1'b0;
            if (cmdDone) begin
                memMode_q <= 1'b0;
                if (cmdByte == `PSC_CMD_RESET) begin
                    memLoad_q <= 1'b1;
                end else if (cmdByte[7:4] == 4'(`PSC_CMD_MEM_BASE >> 4) && !cmdByte[0]) begin
                    memMode_q <= 1'b1;
                    memAddr_q <= cmdByte[3:1];
                end else if ((cmdByte[7:4] == 4'(`PSC_CMD_PRESS_BASE >> 4)
                             || cmdByte[7:4] == 4'(`PSC_CMD_TEMP_BASE >> 4))
                             && !cmdByte[0] && cmdByte[3:1] <= 3'd4) begin
                    conv.start  <= 1'b1;
                    conv.isTemp <= cmdByte[4];
                    conv.ratio  <= cmdByte[3:1];
                end
            end
        end
    end

    // Conversion timer; time scales with the ratio step
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            convCnt_q     <= '0;
            busy          <= 1'b0;
            resultValid_q <= 1'b0;
            corrupt_q     <= 1'b0;
            txData_q      <= '0;
        end else if (clkEn) begin
            if (cmdDone && cmdByte == `PSC_CMD_RESET) begin
                busy          <= 1'b0;
                resultValid_q <= 1'b0;
                convCnt_q     <= '0;
            end else if (conv.start) begin
                busy          <= 1'b1;
                resultValid_q <= 1'b0;
                corrupt_q     <= busy;
                convCnt_q     <= 32'(CONV_CYC << conv.ratio);
            end else if (busy) begin
                convCnt_q <= convCnt_q - 32'd1;
                if (convCnt_q <= 32'd1) begin
                    busy          <= 1'b0;
                    resultValid_q <= !corrupt_q;
                end
            end
            // Load answer once the read address is acknowledged
            if (state_q == psc_pkg::ST_AACK && sclRise && rnw_q) begin
                if (memActive) begin
                    txData_q <= {memWord, 8'h00};
                end else if (resultValid_q && !busy) begin
                    txData_q      <= convTemp ? raw_temperature_value : raw_pressure_value;
                    resultValid_q <= 1'b0;
                end else begin
                    txData_q <= '0;
                    if (busy) begin
                        corrupt_q <= 1'b1;
                    end
                end
            end else if (state_q == psc_pkg::ST_TX && sclRise) begin
                txData_q <= {txData_q[22:0], 1'b0};
            end
        end
    end

    // Output pins and conversion request, all from flops
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sdaOut             <= 1'b1;
            sdaOe              <= 1'b0;
            convStart          <= 1'b0;
            convTemp           <= 1'b0;
            oversampling_ratio <= '0;
        end else if (clkEn) begin
            convStart <= conv.start;
            if (conv.start) begin
                convTemp           <= conv.isTemp;
                oversampling_ratio <= conv.ratio;
            end
            if (startCond || stopCond) begin
                sdaOe  <= 1'b0;
                sdaOut <= 1'b1;
            end else if (sclFall) begin
                unique case (state_q)
                    psc_pkg::ST_AACK, psc_pkg::ST_CACK: begin
                        sdaOe  <= 1'b1;
                        sdaOut <= 1'b0;
                    end
                    psc_pkg::ST_TX: begin
                        sdaOe  <= !txData_q[23];
                        sdaOut <= 1'b0;
                    end
                    psc_pkg::ST_IDLE, psc_pkg::ST_ADDR, psc_pkg::ST_CMD, psc_pkg::ST_MACK: begin
                        sdaOe  <= 1'b0;
                        sdaOut <= 1'b1;
                    end
                endcase
            end
        end
    end
endmodule

// file: sim/psc_i2c_port_props.sv
// Concurrent checks on the command port pins
module psc_i2c_port_props #(
    parameter int CONV_US_256 = 600,
    parameter int CLK_MHZ     = 40
) (
    input wire logic       sys_clk,
    input wire logic       srst,
    input wire logic       clkEn,
    input wire logic       sclIn,
    input wire logic       sdaOut,
    input wire logic       sdaOe,
    input wire logic       convStart,
    input wire logic       convTemp,
    input wire logic [2:0] oversampling_ratio,
    input wire logic       busy
);
    // Longest conversion is sixteen base periods; slack covers start-up
    localparam int MAX_BUSY = CONV_US_256 * CLK_MHZ * 16 + 8;
    int busyCnt_q;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    always_ff @(posedge sys_clk) begin
        // Frozen cycles do not count towards the conversion time
        busyCnt_q <= (srst || !busy) ? 0 : busyCnt_q + int'(clkEn);
    end
    chk_drive_low_only: assert property (sdaOe |-> !sdaOut)
        else $error("sda driven high");
    chk_sda_scl_low: assert property ($changed(sdaOe) |-> !sclIn)
        else $error("sda moved while scl high");
    chk_start_pulse: assert property (convStart |=> !convStart)
        else $error("start pulse too long");
    chk_busy_soon: assert property (convStart |-> ##[0:2] busy)
        else $error("busy missing after start");
    chk_busy_min: assert property ($rose(busy) |-> busy [*8])
        else $error("conversion too short");
    chk_busy_bound: assert property (busyCnt_q <= MAX_BUSY)
        else $error("conversion never ends");
    chk_ratio_legal: assert property (convStart |-> oversampling_ratio <= 3'h4)
        else $error("ratio out of range");
    chk_reset_idle: assert property ($fell(srst) |-> !sdaOe && !busy && !convStart)
        else $error("outputs not idle after reset");
    cover property (convStart && convTemp);
    cover property ($fell(busy));
    cover property ($rose(sdaOe) && !busy);
endmodule
bind psc_i2c_port psc_i2c_port_props #(.CONV_US_256(CONV_US_256), .CLK_MHZ(CLK_MHZ)) u_props (
    .sys_clk(sys_clk), .srst(srst), .clkEn(clkEn), .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .convStart(convStart), .convTemp(convTemp),
    .oversampling_ratio(oversampling_ratio), .busy(busy));

// file: sim/psc_i2c_master.sv
// Behavioural I2C bus master facing the command port
module psc_i2c_master (
    input  wire logic sys_clk,
    output logic      scl,
    output logic      sdaPull,
    input  wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        scl     <= 1'b1;
        sdaPull <= 1'b0;
    end
    // Pins move only on clock edges; a bit spans eight cycles, 200 ns
    task automatic waitc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic start();
        waitc(4);
        sdaPull <= 1'b1;
        waitc(4);
        scl <= 1'b0;
    endtask
    // frame close; clock then rests high
    task automatic stop();
        waitc(1);
        sdaPull <= 1'b1;
        waitc(3);
        scl <= 1'b1;
        waitc(4);
        sdaPull <= 1'b0;
        waitc(4);
    endtask
    // Data moves one cycle after the fall so the slave keeps its hold time
    task automatic bitx(input logic b, output logic r);
        waitc(1);
        sdaPull <= !b;
        waitc(3);
        scl <= 1'b1;
        waitc(4);
        r = sda;
        scl <= 1'b0;
    endtask
    task automatic wrByte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        bitx(1'b1, r);
        ack = !r;
    endtask
    // acknowledge all but the last byte
    task automatic rdByte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
        bitx(last, r);
    endtask
    // clock out a slave stuck in acknowledge
    task automatic pulses(input int n);
        logic r;
        repeat (n) bitx(1'b1, r);
    endtask
endmodule

// file: sim/psc_i2c_port_tb_top.sv
// Testbench of the pressure sensor command port
`include "psc_regs.svh"
module psc_i2c_port_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic         sys_clk, srst, clkEn, asp, scl, mPull, sdaOe, sdaOut, convTemp, busy;
    logic [2:0]   ratio;
    logic [127:0] cal;
    logic [23:0]  rawP, rawT;
    int           n_mismatch = 0, checks_done = 0, cycles = 0;
    wire          sda = !(mPull || sdaOe);
    psc_i2c_port #(.CONV_US_256(1), .CLK_MHZ(40)) uut (
        .sys_clk(sys_clk), .srst(srst), .clkEn(clkEn), .sclIn(scl), .sdaIn(sda),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .address_select_pin(asp), .calContents(cal),
        .convStart(), .convTemp(convTemp), .oversampling_ratio(ratio),
        .raw_pressure_value(rawP), .raw_temperature_value(rawT), .busy(busy));
    psc_i2c_master mst (.sys_clk(sys_clk), .scl(scl), .sdaPull(mPull), .sda(sda));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = !sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask
    function automatic logic [6:0] own();
        return {`PSC_ADDR_HI, !asp};
    endfunction
    task automatic cmd(input logic [7:0] c, input logic [6:0] a, output logic ack);
        logic r;
        mst.start();
        mst.wrByte({a, 1'b0}, ack);
        mst.wrByte(c, r);
        mst.stop();
        ack = ack && r;
    endtask
    task automatic rd(input int n, output logic [23:0] v);
        logic       a;
        logic [7:0] b;
        v = '0;
        mst.start();
        mst.wrByte({own(), 1'b1}, a);
        for (int i = 0; i < n; i++) begin
            mst.rdByte(i == n - 1, b);
            v = {v[15:0], b};
        end
        mst.stop();
        check(a, 1'b1, "read address ack");
    endtask
    task automatic wait_idle();
        for (int t = 0; t < 1000 && busy !== 1'b0; t++) @(posedge sys_clk);
        check(busy, 1'b0, "conversion end");
    endtask
    task automatic s_address();
        logic        ack;
        logic [23:0] v;
        for (int p = 0; p < 2; p++) begin
            @(posedge sys_clk) asp <= p[0];
            @(posedge sys_clk);
            cmd(8'hff, {`PSC_ADDR_HI, p[0]}, ack);
            check(ack, 1'b0, "foreign address");
            cmd(`PSC_CMD_RESET, own(), ack);
            check(ack, 1'b1, "own address reset");
        end
        rd(3, v);
        check(v, 24'h0, "read before conversion");
    endtask
    task automatic s_memory();
        logic        ack;
        logic [23:0] v;
        for (int w = 0; w < `PSC_MEM_WORDS; w++) begin
            cmd(`PSC_CMD_MEM_BASE + 8'(2 * w), own(), ack);
            rd(2, v);
            check({ack, v[15:0]}, {1'b1, cal[16*w+:16]}, "memory word");
        end
    endtask
    task automatic s_convert();
        logic        ack;
        logic [23:0] v;
        for (int k = 0; k < 10; k++) begin
            cmd(`PSC_CMD_PRESS_BASE + 8'(k / 5 * 16 + k % 5 * 2), own(), ack);
            check({ack, busy, convTemp, ratio}, {2'b11, 1'(k/5), 3'(k%5)}, "start");
            wait_idle();
            rd(3, v);
            check(v, (k < 5) ? rawP : rawT, "result");
            rd(3, v);
            check(v, 24'h0, "repeated read");
        end
    endtask
    task automatic s_midread();
        logic        ack;
        logic [23:0] v;
        cmd(`PSC_CMD_TEMP_BASE + 8'h08, own(), ack);
        rd(3, v);
        check({busy, v}, {1'b1, 24'h0}, "read while busy");
        wait_idle();
        rd(3, v);
        check(v, 24'h0, "corrupted result");
    endtask
    task automatic s_recover();
        logic ack;
        cmd(`PSC_CMD_PRESS_BASE + 8'h08, own(), ack);
        mst.start();
        mst.wrByte({own(), 1'b1}, ack);
        mst.pulses(9);
        mst.stop();
        cmd(`PSC_CMD_RESET, own(), ack);
        // Reset arrives while the conversion still runs and must cancel it
        check({ack, busy}, 2'b10, "reset after recovery");
    endtask
    task automatic s_freeze();
        logic        ack;
        logic [23:0] v;
        cmd(`PSC_CMD_PRESS_BASE + 8'h08, own(), ack);
        clkEn <= 1'b0;
        repeat (700) @(posedge sys_clk);
        check({ack, busy}, 2'b11, "frozen conversion");
        clkEn <= 1'b1;
        wait_idle();
        rd(3, v);
        check(v, rawP, "result after freeze");
    endtask
    initial begin
        srst = 1'b1;
        clkEn = 1'b1;
        asp = 1'b0;
        cal = 128'h7777_6666_5555_4444_3333_2222_1111_a5c3;
        rawP = 24'hc0ffe1;
        rawT = 24'h5a1234;
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        s_address();
        s_memory();
        s_convert();
        s_midread();
        s_recover();
        s_freeze();
        report_and_stop();
    end
endmodule
